//--- src/atc_aux_timer_capture_reload.sv
// auxiliary timer, core timer and shared capture/reload register
// assumes pins synchronous-ish to MCLK, count ticks from an outside prescaler
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module atc_aux_timer_capture_reload
    import atc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [4:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic AUX_COUNT_TICK,
    input wire logic CORE_COUNT_TICK,
    input wire logic AUX_COUNT_PIN,
    input wire logic AUX_DIR_PIN,
    input wire logic CAPTURE_PIN,
    input wire logic FIRST_BLOCK_COUNT_INPUT,
    input wire logic FIRST_BLOCK_DIR_INPUT,
    output logic CAPTURE_RELOAD_IRQ,
    output logic CORE_TIMER_IRQ
);

    // ==========================================================
    // bus slave: one wait cycle per access
    logic ack;
    logic [15:0] aux_ctrl;
    logic [15:0] core_ctrl;
    logic core_toggle_latch;
    logic [15:0] aux_timer;
    logic [15:0] core_timer;
    logic [15:0] capture_reload_reg;

    wire req = READ | WRITE;
    wire wr_en = WRITE & ack;
    wire rd_load = READ & ~ack;
    wire sel_aux_ctrl = (ADDRESS == OFF_AUX_CTRL);
    wire sel_core_ctrl = (ADDRESS == OFF_CORE_CTRL);
    wire sel_aux = (ADDRESS == OFF_AUX_TIMER);
    wire sel_core = (ADDRESS == OFF_CORE_TIMER);
    wire sel_cap = (ADDRESS == OFF_CAP_RELOAD);
    wire wr_aux_ctrl = wr_en & sel_aux_ctrl;
    wire wr_core_ctrl = wr_en & sel_core_ctrl;
    wire wr_aux = wr_en & sel_aux;
    wire wr_core = wr_en & sel_core;
    wire wr_cap = wr_en & sel_cap;
    wire [15:0] be_mask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

    assign WAITREQUEST = req & ~ack;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [15:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction : merge

    wire [15:0] core_ctrl_view = {core_ctrl[15:CORE_TL_BIT + 1], core_toggle_latch, core_ctrl[CORE_TL_BIT - 1:0]};
    wire [15:0] rd_mux = sel_aux_ctrl ? aux_ctrl :
                         sel_core_ctrl ? core_ctrl_view :
                         sel_aux ? aux_timer :
                         sel_core ? core_timer :
                         sel_cap ? capture_reload_reg : 16'h0000;
    wire [15:0] core_ctrl_wr = merge(core_ctrl_view, WRITEDATA[15:0], be_mask);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ack <= 1'b0;
            READDATA <= 32'h0000_0000;
        end else begin
            ack <= req & ~ack;
            if (rd_load) begin
                READDATA <= {16'h0000, rd_mux};
            end
        end
    end

    // ==========================================================
    // control registers
    wire [2:0] aux_input_select = aux_ctrl[AUX_SEL_LSB +: 3];
    wire [2:0] aux_mode_field = aux_ctrl[AUX_MODE_LSB +: 3];
    wire aux_run_bit = aux_ctrl[AUX_RUN_BIT];
    wire aux_direction = aux_ctrl[AUX_DIR_BIT];
    wire aux_ext_direction_enable = aux_ctrl[AUX_EXTDIR_BIT];
    wire aux_remote_control = aux_ctrl[AUX_REMOTE_BIT];
    wire capture_source_select = aux_ctrl[CAP_SRC_BIT];
    wire capture_correction = aux_ctrl[CAP_CORR_BIT];
    wire [1:0] capture_edge_select = aux_ctrl[CAP_EDGE_LSB +: 2];
    wire aux_clear_on_capture = aux_ctrl[AUX_CLR_BIT];
    wire capture_enable = aux_ctrl[CAP_EN_BIT];
    wire core_run_bit = core_ctrl[CORE_RUN_BIT];
    wire core_down = core_ctrl[CORE_DIR_BIT];
    wire core_clear_on_capture = core_ctrl[CORE_CLR_BIT];
    wire reload_enable = core_ctrl[RELOAD_EN_BIT];

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            aux_ctrl <= CTRL_RESET;
            core_ctrl <= CTRL_RESET;
        end else begin
            if (wr_aux_ctrl) begin
                aux_ctrl <= merge(aux_ctrl, WRITEDATA[15:0], be_mask);
            end
            if (wr_core_ctrl) begin
                core_ctrl <= core_ctrl_wr;
            end
        end
    end

    // ==========================================================
    // pin synchronisers and edge detection
    wire [4:0] pins_raw = {FIRST_BLOCK_DIR_INPUT, FIRST_BLOCK_COUNT_INPUT, CAPTURE_PIN, AUX_DIR_PIN, AUX_COUNT_PIN};
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
            pin_prev <= 5'h00;
        end else begin
            pin_meta <= pins_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire [4:0] pin_rise = pin_sync & ~pin_prev;
    wire [4:0] pin_fall = ~pin_sync & pin_prev;
    wire [4:0] pin_any = pin_rise | pin_fall;

    // ==========================================================
    // core timer with toggle latch and reload
    wire core_tick = core_run_bit & CORE_COUNT_TICK;
    wire core_ovf = core_tick & (core_down ? (core_timer == TIMER_RESET) : (core_timer == TIMER_MAX));
    wire tl_rise = core_ovf & ~core_toggle_latch;
    wire tl_fall = core_ovf & core_toggle_latch;

    // ==========================================================
    // capture trigger decode
    wire trig_pin = (capture_edge_select[0] & pin_rise[2]) | (capture_edge_select[1] & pin_fall[2]);
    wire trig_first = (capture_edge_select[0] & pin_any[3]) | (capture_edge_select[1] & pin_any[4]);
    wire cap_trig = capture_source_select ? trig_first : trig_pin;
    wire cap_latch = cap_trig & capture_enable;
    wire [15:0] cap_value = capture_correction ? aux_timer - TIMER_ONE : aux_timer;

    wire [15:0] core_next = wr_core ? merge(core_timer, WRITEDATA[15:0], be_mask) :
                            (cap_trig & core_clear_on_capture) ? TIMER_RESET :
                            (core_ovf & reload_enable) ? capture_reload_reg :
                            core_tick ? (core_down ? core_timer - TIMER_ONE : core_timer + TIMER_ONE) :
                            core_timer;
    wire next_latch = wr_core_ctrl ? core_ctrl_wr[CORE_TL_BIT] : (core_toggle_latch ^ core_ovf);

    // ==========================================================
    // aux timer step decode
    wire aux_run = aux_remote_control ? core_run_bit : aux_run_bit;
    wire gate_open = (pin_sync[0] == aux_mode_field[0]);
    wire pin_hit = (aux_input_select[0] & pin_rise[0]) | (aux_input_select[1] & pin_fall[0]);
    wire tl_hit = (aux_input_select[0] & tl_rise) | (aux_input_select[1] & tl_fall);
    wire edge_hit = aux_input_select[2] ? tl_hit : pin_hit;
    wire mode_timer = (aux_mode_field == MODE_TIMER);
    wire mode_counter = (aux_mode_field == MODE_COUNTER);
    wire mode_gated = (aux_mode_field == MODE_GATE_LOW) | (aux_mode_field == MODE_GATE_HIGH);
    wire aux_step = aux_run & ((mode_timer & AUX_COUNT_TICK) |
                               (mode_gated & AUX_COUNT_TICK & gate_open) |
                               (mode_counter & edge_hit));
    wire aux_down = aux_ext_direction_enable ? (aux_direction ^ pin_sync[1]) : aux_direction;
    wire [15:0] aux_next = wr_aux ? merge(aux_timer, WRITEDATA[15:0], be_mask) :
                           (cap_trig & aux_clear_on_capture) ? TIMER_RESET :
                           aux_step ? (aux_down ? aux_timer - TIMER_ONE : aux_timer + TIMER_ONE) :
                           aux_timer;
    wire [15:0] cap_next = cap_latch ? cap_value :
                           wr_cap ? merge(capture_reload_reg, WRITEDATA[15:0], be_mask) :
                           capture_reload_reg;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            core_timer <= TIMER_RESET;
            core_toggle_latch <= 1'b0;
            aux_timer <= TIMER_RESET;
            capture_reload_reg <= TIMER_RESET;
            CAPTURE_RELOAD_IRQ <= 1'b0;
            CORE_TIMER_IRQ <= 1'b0;
        end else begin
            core_timer <= core_next;
            core_toggle_latch <= next_latch;
            aux_timer <= aux_next;
            capture_reload_reg <= cap_next;
            CAPTURE_RELOAD_IRQ <= cap_trig;
            CORE_TIMER_IRQ <= core_ovf;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    wire aux_quiet = ~wr_aux & ~(cap_trig & aux_clear_on_capture);

    chk_timer_mode_step: assert property (
        (mode_timer & aux_run & AUX_COUNT_TICK & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("timer mode did not step up");

    chk_gate_closed_hold: assert property (
        (mode_gated & ~gate_open & aux_quiet) |=> $stable(aux_timer))
        else $error("gated timer counted with gate closed");

    chk_irq_cause: assert property (
        $rose(CAPTURE_RELOAD_IRQ) |-> $past(cap_trig))
        else $error("capture request without a trigger");

    chk_counter_off_hold: assert property (
        (mode_counter & (aux_input_select[1:0] == 2'b00) & aux_quiet) |=> $stable(aux_timer))
        else $error("counter with select X00 moved");

    chk_sw_latch_nocount: assert property (
        (mode_counter & aux_input_select[2] & ~core_ovf & aux_quiet) |=> $stable(aux_timer))
        else $error("aux counted without core overflow");

    chk_chain_32bit: assert property (
        (mode_counter & (aux_input_select == 3'h7) & aux_run & core_ovf & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("32-bit chain missed a carry");

    chk_capture_value: assert property (
        cap_latch |=> capture_reload_reg == $past(cap_value) && CAPTURE_RELOAD_IRQ)
        else $error("capture value or request wrong");

    chk_correction: assert property (
        (cap_latch & capture_correction) |=> capture_reload_reg == $past(aux_timer) - TIMER_ONE)
        else $error("capture correction not applied");

    chk_aux_clear: assert property (
        (cap_trig & aux_clear_on_capture & ~wr_aux) |=> aux_timer == TIMER_RESET)
        else $error("aux timer not cleared on capture");

    chk_disabled_capture: assert property (
        (cap_trig & ~capture_enable & ~wr_cap) |=> $stable(capture_reload_reg) && CAPTURE_RELOAD_IRQ)
        else $error("disabled capture latched or lost request");

    chk_reload_load: assert property (
        (core_ovf & reload_enable & ~wr_core & ~(cap_trig & core_clear_on_capture))
        |=> core_timer == $past(capture_reload_reg) && CORE_TIMER_IRQ)
        else $error("core timer not reloaded");

    chk_reload_no_cr: assert property (
        (core_ovf & ~cap_trig) |=> ~CAPTURE_RELOAD_IRQ)
        else $error("reload raised capture request");

    chk_remote_run: assert property (
        (aux_remote_control & ~core_run_bit & aux_quiet) |=> $stable(aux_timer))
        else $error("remote stopped aux timer moved");

    chk_gate_open_step: assert property (
        (mode_gated & gate_open & aux_run & AUX_COUNT_TICK & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("open gate did not step");

    chk_gate_no_irq: assert property (
        (mode_gated & pin_any[0] & ~cap_trig) |=> ~CAPTURE_RELOAD_IRQ)
        else $error("gate edge raised a request");

    chk_pin_rise_count: assert property (
        (mode_counter & (aux_input_select == 3'h1) & pin_rise[0] & aux_run & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("rising pin edge not counted");

    chk_pin_fall_count: assert property (
        (mode_counter & (aux_input_select == 3'h2) & pin_fall[0] & aux_run & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("falling pin edge not counted");

    chk_pin_any_down: assert property (
        (mode_counter & (aux_input_select == 3'h3) & pin_any[0] & aux_run & aux_quiet & aux_down)
        |=> aux_timer == $past(aux_timer) - TIMER_ONE)
        else $error("any pin edge not counted down");

    chk_latch_write_quiet: assert property (
        (wr_core_ctrl & mode_counter & aux_input_select[2] & ~core_ovf & aux_quiet)
        |=> $stable(aux_timer))
        else $error("latch write counted aux");

    chk_latch_rise_only: assert property (
        (mode_counter & (aux_input_select == 3'h5) & tl_fall & aux_quiet) |=> $stable(aux_timer))
        else $error("33-bit chain counted a fall");

    chk_chain_33bit: assert property (
        (mode_counter & (aux_input_select == 3'h5) & tl_rise & aux_run & aux_quiet & ~aux_down)
        |=> aux_timer == $past(aux_timer) + TIMER_ONE)
        else $error("33-bit chain missed a carry");

    chk_chain_down: assert property (
        (mode_counter & (aux_input_select == 3'h7) & core_ovf & aux_run & aux_quiet & aux_down)
        |=> aux_timer == $past(aux_timer) - TIMER_ONE)
        else $error("chain ignored aux direction");

    chk_core_step: assert property (
        (core_tick & ~core_ovf & ~wr_core & ~(cap_trig & core_clear_on_capture) & ~core_down)
        |=> core_timer == $past(core_timer) + TIMER_ONE)
        else $error("core timer did not step up");

    chk_run_stop: assert property (
        (~aux_remote_control & ~aux_run_bit & aux_quiet) |=> $stable(aux_timer))
        else $error("stopped aux timer moved");

    chk_remote_step: assert property (
        (aux_remote_control & core_run_bit & ~aux_run_bit & mode_timer & AUX_COUNT_TICK & aux_quiet & aux_down)
        |=> aux_timer == $past(aux_timer) - TIMER_ONE)
        else $error("remote run did not step");

    chk_trigger_off: assert property (
        ((capture_edge_select == 2'b00) & ~wr_cap)
        |=> $stable(capture_reload_reg) && ~CAPTURE_RELOAD_IRQ)
        else $error("capture with select 00");

    chk_pin_trigger: assert property (
        (~capture_source_select & (capture_edge_select == 2'b01) & pin_rise[2]) |=> CAPTURE_RELOAD_IRQ)
        else $error("rising capture edge missed");

    chk_fall_trigger: assert property (
        (~capture_source_select & (capture_edge_select == 2'b10) & pin_fall[2]) |=> CAPTURE_RELOAD_IRQ)
        else $error("falling capture edge missed");

    chk_block_trigger: assert property (
        (capture_source_select & (capture_edge_select == 2'b10) & pin_any[4]) |=> CAPTURE_RELOAD_IRQ)
        else $error("direction input edge missed");

    chk_block_ignore: assert property (
        (capture_source_select & (capture_edge_select == 2'b01) & ~pin_any[3]) |=> ~CAPTURE_RELOAD_IRQ)
        else $error("capture without count input edge");

    chk_core_clear: assert property (
        (cap_trig & core_clear_on_capture & ~wr_core) |=> core_timer == TIMER_RESET)
        else $error("core timer not cleared on capture");

    chk_no_clear: assert property (
        (cap_trig & ~aux_clear_on_capture & ~wr_aux & ~aux_step) |=> $stable(aux_timer))
        else $error("aux timer cleared without clear bit");

    chk_core_irq: assert property (
        core_ovf |=> CORE_TIMER_IRQ)
        else $error("core overflow without request");

    chk_ext_direction: assert property (
        (mode_timer & aux_run & AUX_COUNT_TICK & aux_quiet & aux_ext_direction_enable & ~aux_direction & pin_sync[1])
        |=> aux_timer == $past(aux_timer) - TIMER_ONE)
        else $error("external direction ignored");

    chk_wrap_up: assert property (
        (aux_step & ~aux_down & aux_quiet & (aux_timer == TIMER_MAX)) |=> aux_timer == TIMER_RESET)
        else $error("aux timer did not wrap up");

    chk_wrap_down: assert property (
        (aux_step & aux_down & aux_quiet & (aux_timer == TIMER_RESET)) |=> aux_timer == TIMER_MAX)
        else $error("aux timer did not wrap down");

    cov_capture: cover property (cap_latch ##1 CAPTURE_RELOAD_IRQ);
    cov_reload: cover property (core_ovf & reload_enable);
    cov_chain33: cover property (mode_counter & (aux_input_select == 3'h5) & tl_rise & aux_run);
    cov_gated: cover property (mode_gated & aux_step);
    cov_clear_only: cover property (cap_trig & ~capture_enable & aux_clear_on_capture);

endmodule : atc_aux_timer_capture_reload

//--- src/atc_pkg.sv
// constants for the auxiliary timer with capture/reload register
// assumes one 250 MHz clock and an Avalon-MM slave port
// Function
// - mode 000 counts prescaled count tick
// - modes 010/011 gate counting, bit0 level
// - gate level changes raise no request
// - mode 001 counts pin or latch edges
// - input select picks counting edge, X00 off
// - software latch writes never count
// - both latch edges give 32-bit chain
// - one latch edge gives 33-bit chain
// - each chained timer keeps own direction
// - toggle latch readable in core control, no output pin here
// - run from own or core run bit
// - capture enable selects capture mode
// - trigger select decodes pin or first block
// - trigger copies aux timer, raises request
// - clear bits clear timers after latching
// - capture enable gates only the latching
// - reload enable reloads core on overflow
// - reload raises core request, not capture
// - remote bit selects which run bit
// - correction stores aux value minus one
// - direction bit, inverted by pin under external direction
package atc_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [4:0] OFF_AUX_CTRL = 5'h00;
    localparam logic [4:0] OFF_CORE_CTRL = 5'h04;
    localparam logic [4:0] OFF_AUX_TIMER = 5'h08;
    localparam logic [4:0] OFF_CORE_TIMER = 5'h0C;
    localparam logic [4:0] OFF_CAP_RELOAD = 5'h10;

    // ==========================================================
    // aux_timer_control fields
    localparam int AUX_SEL_LSB = 0;
    localparam int AUX_MODE_LSB = 3;
    localparam int AUX_RUN_BIT = 6;
    localparam int AUX_DIR_BIT = 7;
    localparam int AUX_EXTDIR_BIT = 8;
    localparam int AUX_REMOTE_BIT = 9;
    localparam int CAP_SRC_BIT = 10;
    localparam int CAP_CORR_BIT = 11;
    localparam int CAP_EDGE_LSB = 12;
    localparam int AUX_CLR_BIT = 14;
    localparam int CAP_EN_BIT = 15;

    // ==========================================================
    // core_timer_control fields
    localparam int CORE_RUN_BIT = 6;
    localparam int CORE_DIR_BIT = 7;
    localparam int CORE_TL_BIT = 10;
    localparam int CORE_CLR_BIT = 14;
    localparam int RELOAD_EN_BIT = 15;

    // ==========================================================
    // modes and reset values
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_COUNTER = 3'h1;
    localparam logic [2:0] MODE_GATE_LOW = 3'h2;
    localparam logic [2:0] MODE_GATE_HIGH = 3'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] TIMER_RESET = 16'h0000;
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;
    localparam logic [15:0] TIMER_ONE = 16'h0001;

endpackage : atc_pkg

//--- verif/atc_pin_model.sv
// outside trigger and count sources for the timer block
// assumes the bench asks for levels on want; each level is held at least HOLD+1 cycles
`timescale 1ns/1ps
module atc_pin_model
    import atc_pkg::*;
#(
    parameter int HOLD = 4
)(
    input wire logic clk,
    input wire logic [4:0] want,
    output logic [4:0] pins
);
    int age [5];
    initial pins = 5'h00;
    // ==========================================
    // a level may change only once it has stood long enough
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (pins[i] != want[i] && age[i] >= HOLD) begin
                pins[i] <= want[i];
                age[i] <= 0;
            end else begin
                age[i] <= age[i] + 1;
            end
        end
    end
endmodule : atc_pin_model

//--- verif/tb.sv
// self-checking bench for the aux timer with capture/reload register
// assumes atc_pkg, the pin model and an Avalon master with waitrequest
`timescale 1ns/1ps
module tb;
    import atc_pkg::*;
    logic MCLK = 1'b0, RST_N = 1'b0, READ = 1'b0, WRITE = 1'b0;
    logic AUX_COUNT_TICK = 1'b0, CORE_COUNT_TICK = 1'b0;
    logic [4:0] ADDRESS = 5'h00, want = 5'h00, pins;
    logic [31:0] WRITEDATA = 32'h00000000, READDATA, rd;
    logic [3:0] BYTEENABLE = 4'h3;
    logic WAITREQUEST, CAPTURE_RELOAD_IRQ, CORE_TIMER_IRQ;
    int n_fail = 0, n_tests = 0, n_cap = 0, n_core = 0, exp_cap = 0, exp_core = 0;
    int seed = 26, ea, w, cr;
    always #2 MCLK = ~MCLK;
    atc_pin_model i_atc_pin_model (.clk(MCLK), .want(want), .pins(pins));
    atc_aux_timer_capture_reload i_atc_aux_timer_capture_reload (.MCLK(MCLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
        .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .AUX_COUNT_TICK(AUX_COUNT_TICK), .CORE_COUNT_TICK(CORE_COUNT_TICK),
        .AUX_COUNT_PIN(pins[0]), .AUX_DIR_PIN(pins[1]), .CAPTURE_PIN(pins[2]),
        .FIRST_BLOCK_COUNT_INPUT(pins[3]), .FIRST_BLOCK_DIR_INPUT(pins[4]),
        .CAPTURE_RELOAD_IRQ(CAPTURE_RELOAD_IRQ), .CORE_TIMER_IRQ(CORE_TIMER_IRQ));
    always @(posedge MCLK) begin
        if (CAPTURE_RELOAD_IRQ === 1'b1) n_cap <= n_cap + 1;
        if (CORE_TIMER_IRQ === 1'b1) n_core <= n_core + 1;
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        int k;
        logic wq;
        k = 0;
        ADDRESS <= a;
        WRITEDATA <= {16'h0000, d};
        WRITE <= wr;
        READ <= ~wr;
        do begin
            @(negedge MCLK);
            wq = WAITREQUEST;
            @(posedge MCLK);
            k++;
        end while (wq !== 1'b0 && k < 100);
        if (wq !== 1'b0) n_fail++;
        rd = READDATA;
        WRITE <= 1'b0;
        READ <= 1'b0;
        @(posedge MCLK);
    endtask : bus
    task automatic rchk(input string nm, input logic [4:0] a, input int e);
        bus(1'b0, a, 16'h0000);
        chk(nm, rd, {16'h0000, e[15:0]});
    endtask : rchk
    task automatic tick(input int n, input logic core);
        repeat (n) begin
            AUX_COUNT_TICK <= ~core;
            CORE_COUNT_TICK <= core;
            @(posedge MCLK);
            AUX_COUNT_TICK <= 1'b0;
            CORE_COUNT_TICK <= 1'b0;
            @(posedge MCLK);
        end
        repeat (3) @(posedge MCLK);
    endtask : tick
    task automatic pin(input int i, input logic v);
        want[i] <= v;
        repeat (12) @(posedge MCLK);
    endtask : pin
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // suite needs about 600 cycles
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
    // ==========================================
    // scenarios
    initial begin
        repeat (3) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        for (int a = 0; a < 24; a += 4) rchk("reset", a[4:0], 0);
        bus(1'b1, 5'h14, 16'h1234);
        ea = 3 + $unsigned($random(seed)) % 8;
        bus(1'b1, OFF_AUX_CTRL, 16'h0040);
        tick(ea, 1'b0);
        rchk("timer", OFF_AUX_TIMER, ea);
        bus(1'b1, OFF_AUX_CTRL, 16'h0280);
        tick(2, 1'b0);
        rchk("remote stop", OFF_AUX_TIMER, ea);
        bus(1'b1, OFF_CORE_CTRL, 16'h0040);
        tick(ea + 1, 1'b0);
        rchk("down wrap", OFF_AUX_TIMER, 'hFFFF);
        bus(1'b1, OFF_CORE_CTRL, 16'h0000);
        bus(1'b1, OFF_AUX_TIMER, 16'h0000);
        bus(1'b1, OFF_AUX_CTRL, 16'h0058);
        tick(4, 1'b0);
        rchk("gate shut", OFF_AUX_TIMER, 0);
        pin(0, 1'b1);
        tick(4, 1'b0);
        rchk("gate open", OFF_AUX_TIMER, 4);
        bus(1'b1, OFF_AUX_CTRL, 16'h0050);
        tick(4, 1'b0);
        pin(0, 1'b0);
        tick(2, 1'b0);
        rchk("gate low", OFF_AUX_TIMER, 6);
        chk("gate irq", n_cap, exp_cap);
        ea = 6;
        for (int s = 1; s < 5; s++) begin
            bus(1'b1, OFF_AUX_CTRL, 16'h0048 | s[15:0]);
            pin(0, ~want[0]);
            pin(0, ~want[0]);
            ea += (s == 3) ? 2 : (s == 4) ? 0 : 1;
            rchk("pin edges", OFF_AUX_TIMER, ea);
        end
        for (int s = 5; s < 8; s += 2) begin
            bus(1'b1, OFF_AUX_CTRL, 16'h0048 | s[15:0]);
            bus(1'b1, OFF_AUX_TIMER, 16'h0000);
            bus(1'b1, OFF_CORE_CTRL, 16'h04C0);
            bus(1'b1, OFF_CORE_CTRL, 16'h00C0);
            rchk("soft latch", OFF_AUX_TIMER, 0);
            for (int k = 0; k < 2; k++) begin
                bus(1'b1, OFF_CORE_TIMER, 16'h0000);
                tick(1, 1'b1);
                exp_core++;
            end
            rchk("chain", OFF_AUX_TIMER, (s == 7) ? 2 : 1);
            rchk("core down", OFF_CORE_TIMER, 'hFFFF);
        end
        bus(1'b1, OFF_AUX_CTRL, 16'hD800);
        bus(1'b1, OFF_CORE_CTRL, 16'h4000);
        w = 1 + $unsigned($random(seed)) % 65534;
        bus(1'b1, OFF_AUX_TIMER, w[15:0]);
        bus(1'b1, OFF_CORE_TIMER, 16'h0123);
        pin(2, 1'b1);
        exp_cap++;
        cr = w - 1;
        rchk("corrected", OFF_CAP_RELOAD, cr);
        rchk("aux clear", OFF_AUX_TIMER, 0);
        rchk("core clear", OFF_CORE_TIMER, 0);
        bus(1'b1, OFF_CORE_CTRL, 16'h0000);
        bus(1'b1, OFF_AUX_TIMER, w[15:0]);
        bus(1'b1, OFF_AUX_CTRL, 16'h7000);
        pin(2, 1'b0);
        exp_cap++;
        rchk("no latch", OFF_CAP_RELOAD, cr);
        rchk("clear only", OFF_AUX_TIMER, 0);
        chk("cap irq", n_cap, exp_cap);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, OFF_AUX_CTRL, {2'b10, e[1:0], 12'h400});
            w = $unsigned($random(seed)) % 65536;
            bus(1'b1, OFF_AUX_TIMER, w[15:0]);
            pin(3, ~want[3]);
            pin(4, ~want[4]);
            exp_cap += (e == 0) ? 0 : (e == 3) ? 2 : 1;
            if (e != 0) cr = w;
            chk("block irq", n_cap, exp_cap);
            rchk("block cap", OFF_CAP_RELOAD, cr);
        end
        w = $unsigned($random(seed)) % 65536;
        bus(1'b1, OFF_CAP_RELOAD, w[15:0]);
        bus(1'b1, OFF_CORE_CTRL, 16'h8040);
        bus(1'b1, OFF_CORE_TIMER, 16'hFFFF);
        tick(1, 1'b1);
        exp_core++;
        rchk("reload", OFF_CORE_TIMER, w);
        chk("core irq", n_core, exp_core);
        chk("reload irq", n_cap, exp_cap);
        finish_test;
    end
endmodule : tb
